// File: scc_ctrl.sv
`timescale 1ns/10ps
module scc_ctrl #(
  parameter int OC_CYCLES = scc_pkg::OC_CYCLES,
  parameter int STEP_CYCLES = scc_pkg::SEQ_STEP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic cs_n,
  input wire logic power_request,
  input wire logic mode_status_pin_in,
  output logic mode_status_pin_out,
  output logic mode_status_pin_oe_n,
  input wire logic host_reset,
  input wire logic host_io_in,
  output logic host_io_out,
  output logic host_io_oe_n,
  input wire logic host_aux_four_in,
  output logic host_aux_four_out,
  output logic host_aux_four_oe_n,
  input wire logic host_aux_eight_in,
  output logic host_aux_eight_out,
  output logic host_aux_eight_oe_n,
  input wire logic sync_clock_in,
  input wire logic async_clock_in,
  input wire logic card_present,
  input wire logic card_supply_ok,
  input wire scc_pkg::scc_fault_s faults,
  output logic card_supply_on,
  output logic card_supply_high,
  output logic card_clock_out,
  output logic card_reset_out,
  input wire logic card_serial_line_in,
  output logic card_serial_line_out,
  output logic card_serial_line_oe_n,
  input wire logic card_aux_four_in,
  output logic card_aux_four_out,
  output logic card_aux_four_oe_n,
  input wire logic card_aux_eight_in,
  output logic card_aux_eight_out,
  output logic card_aux_eight_oe_n,
  output logic wake_n,
  output scc_pkg::scc_mode_e mode
);
  scc_pkg::scc_mode_e next_mode;
  scc_pkg::scc_cfg_s cfg;
  logic cs_q;
  logic pr_q;
  logic card_q;
  logic [2:0] lvl;
  logic [15:0] step_cnt;
  logic [24:0] oc_cnt;
  logic deact;
  logic supply_up;
  logic armed;
  logic conv_fault;
  logic [2:0] to_card;
  logic [2:0] to_host;

  // host and card edge events
  wire cs_fall = cs_q & ~cs_n;
  wire cs_rise = ~cs_q & cs_n;
  wire pr_rise = ~pr_q & power_request;
  wire card_arrive = card_present & ~card_q;

  // programming capture and configuration
  wire prog_latch = (mode == scc_pkg::MODE_PROG) & cs_rise & ~mode_status_pin_in;
  wire [1:0] prog_clk = {host_reset, host_io_in};

  // fault detection while the card is powered
  wire oc_trip = (oc_cnt == 25'(OC_CYCLES - 1)) & faults.overcurrent;
  wire trip = card_supply_on & ~deact
    & ((supply_up & faults.supply_uv) | oc_trip | faults.overtemp | ~card_present);
  wire host_off = ~cs_n & ~power_request & card_supply_on & ~deact;
  wire start = (mode == scc_pkg::MODE_ACTIVE) & ~cs_n & power_request & armed
    & card_present & ~card_supply_on & ~deact;
  wire step_done = (step_cnt == 16'h0);
  wire seq_up = card_supply_on & ~deact & card_supply_ok & (lvl < scc_pkg::LVL_RST);

  // card line group enables from the sequencer level
  wire io_en = (lvl >= scc_pkg::LVL_IO);
  wire clk_en = (lvl >= scc_pkg::LVL_CLK);
  wire aux_en = (lvl >= scc_pkg::LVL_AUX);
  wire rst_en = (lvl >= scc_pkg::LVL_RST);
  wire [2:0] line_en = {aux_en, aux_en, io_en};
  wire sync_idle = (mode == scc_pkg::MODE_IDLE) & (cfg.clk_sel == scc_pkg::CLK_SYNC);
  wire clk_run = clk_en & ~sync_idle;

  // status pin: output only while selected and not programming
  wire drive_status = ~cs_n & ~cs_q & (mode != scc_pkg::MODE_PROG);
  wire status_val = power_request ? ~conv_fault : card_present;
  assign mode_status_pin_oe_n = ~drive_status;

  // mode transitions
  always_comb begin
    next_mode = mode;
    case (mode)
      scc_pkg::MODE_STANDBY: begin
        if (cs_fall) begin
          next_mode = mode_status_pin_in ? scc_pkg::MODE_ACTIVE : scc_pkg::MODE_PROG;
        end
      end
      scc_pkg::MODE_PROG: begin
        if (cs_rise) begin
          next_mode = scc_pkg::MODE_STANDBY;
        end
      end
      scc_pkg::MODE_ACTIVE: begin
        if (card_supply_on & ~deact & ~trip & ~host_off & (lvl == scc_pkg::LVL_RST)) begin
          next_mode = scc_pkg::MODE_TRANS;
        end else if (cs_n & ~card_supply_on) begin
          next_mode = scc_pkg::MODE_STANDBY;
        end
      end
      scc_pkg::MODE_TRANS: begin
        if (trip | host_off) begin
          next_mode = scc_pkg::MODE_ACTIVE;
        end else if (cs_n) begin
          next_mode = scc_pkg::MODE_IDLE;
        end
      end
      scc_pkg::MODE_IDLE: begin
        if (trip) begin
          next_mode = scc_pkg::MODE_ACTIVE;
        end else if (~cs_n) begin
          next_mode = scc_pkg::MODE_TRANS;
        end
      end
      default: next_mode = scc_pkg::MODE_STANDBY;
    endcase
  end

  // state register, edge history and configuration
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= scc_pkg::MODE_STANDBY;
      cs_q <= 1'b1;
      pr_q <= 1'b0;
      card_q <= 1'b0;
      cfg <= scc_pkg::CFG_RESET;
    end else begin
      mode <= next_mode;
      cs_q <= cs_n;
      pr_q <= power_request;
      card_q <= card_present;
      if (prog_latch) begin
        cfg <= '{vcc_high: power_request, clk_sel: prog_clk};
      end
    end
  end

  // converter control and activation / deactivation sequencer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      card_supply_on <= 1'b0;
      deact <= 1'b0;
      lvl <= scc_pkg::LVL_OFF;
      step_cnt <= 16'h0;
      supply_up <= 1'b0;
    end else if (deact) begin
      step_cnt <= step_done ? 16'(STEP_CYCLES - 1) : step_cnt - 16'h1;
      if (step_done && lvl != scc_pkg::LVL_OFF) begin
        lvl <= lvl - 3'h1;
      end else if (step_done) begin
        card_supply_on <= 1'b0;
        supply_up <= 1'b0;
        deact <= 1'b0;
      end
    end else if (trip | host_off) begin
      deact <= 1'b1;
      step_cnt <= 16'h0;
    end else if (start) begin
      card_supply_on <= 1'b1;
      step_cnt <= 16'(STEP_CYCLES - 1);
    end else if (seq_up) begin
      supply_up <= 1'b1;
      step_cnt <= step_done ? 16'(STEP_CYCLES - 1) : step_cnt - 16'h1;
      lvl <= step_done ? lvl + 3'h1 : lvl;
    end
  end

  // overcurrent integration, converter status and restart arming
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      oc_cnt <= 25'h0;
      conv_fault <= 1'b0;
      armed <= 1'b1;
    end else begin
      oc_cnt <= (faults.overcurrent & card_supply_on & ~oc_trip) ? oc_cnt + 25'h1 : 25'h0;
      if (trip) begin
        conv_fault <= 1'b1;
      end else if (faults.overtemp | faults.overcurrent) begin
        conv_fault <= 1'b1;
      end else if (start) begin
        conv_fault <= 1'b0;
      end
      if (trip) begin
        armed <= 1'b0;
      end else if (~power_request) begin
        armed <= 1'b1;
      end
    end
  end

  // wake request, status pin data and card reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_n <= 1'b1;
      mode_status_pin_out <= 1'b0;
      card_reset_out <= 1'b0;
    end else begin
      if ((mode == scc_pkg::MODE_STANDBY) & card_arrive) begin
        wake_n <= 1'b0;
      end else if (cs_rise | pr_rise) begin
        wake_n <= 1'b1;
      end
      mode_status_pin_out <= status_val;
      if (!rst_en) begin
        card_reset_out <= 1'b0;
      end else if (!cs_n) begin
        card_reset_out <= host_reset;
      end
    end
  end

  // bidirectional line repeaters: io, aux four, aux eight
  wire [2:0] h_in = {host_aux_eight_in, host_aux_four_in, host_io_in};
  wire [2:0] c_in = {card_aux_eight_in, card_aux_four_in, card_serial_line_in};
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      to_card <= 3'h0;
      to_host <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (!line_en[i]) begin
          to_card[i] <= 1'b0;
          to_host[i] <= 1'b0;
        end else if (!cs_n) begin
          to_card[i] <= ~h_in[i] & ~to_host[i];
          to_host[i] <= ~c_in[i] & ~to_card[i];
        end else begin
          to_host[i] <= 1'b0;
        end
      end
    end
  end

  // open-drain drives; disabled card lines are held at ground
  assign card_serial_line_out = 1'b0;
  assign card_aux_four_out = 1'b0;
  assign card_aux_eight_out = 1'b0;
  assign card_serial_line_oe_n = line_en[0] & ~to_card[0];
  assign card_aux_four_oe_n = line_en[1] & ~to_card[1];
  assign card_aux_eight_oe_n = line_en[2] & ~to_card[2];
  assign host_io_out = 1'b0;
  assign host_aux_four_out = 1'b0;
  assign host_aux_eight_out = 1'b0;
  assign host_io_oe_n = ~(to_host[0] & ~cs_n);
  assign host_aux_four_oe_n = ~(to_host[1] & ~cs_n);
  assign host_aux_eight_oe_n = ~(to_host[2] & ~cs_n);
  assign card_supply_high = cfg.vcc_high;

  // glitch-free card clock selection
  scc_clk_sel u_clk (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .sync_clock_in(sync_clock_in),
    .async_clock_in(async_clock_in),
    .sel(cfg.clk_sel),
    .run(clk_run),
    .card_clock_out(card_clock_out)
  );

  prog_latch_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    prog_latch |=> cfg == {$past(power_request), $past(host_reset), $past(host_io_in)})
    else $error("programming values not captured");
  status_drive_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !mode_status_pin_oe_n |-> !cs_n && mode != scc_pkg::MODE_PROG)
    else $error("status pin driven while deselected");
  status_code_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !power_request |=> mode_status_pin_out == $past(card_present))
    else $error("card status code wrong");
  standby_off_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    mode == scc_pkg::MODE_STANDBY |-> !card_supply_on && lvl == scc_pkg::LVL_OFF)
    else $error("card powered in standby");
  wake_set_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    mode == scc_pkg::MODE_STANDBY && card_arrive |=> !wake_n)
    else $error("wake not asserted on card arrival");
  wake_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (cs_rise || pr_rise) && !(mode == scc_pkg::MODE_STANDBY && card_arrive) |=> wake_n)
    else $error("wake not released");
  trans_entry_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    mode == scc_pkg::MODE_TRANS |-> card_supply_on && lvl == scc_pkg::LVL_RST)
    else $error("transaction without full activation");
  host_down_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    host_off |=> deact ##1 deact)
    else $error("host powerdown not started");
  fault_down_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    trip |=> deact && mode == scc_pkg::MODE_ACTIVE)
    else $error("fault did not start powerdown");
  deact_order_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    deact && !$stable(lvl) |-> lvl == $past(lvl) - 3'h1 && card_supply_on)
    else $error("deactivation out of order");
  supply_last_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $fell(card_supply_on) |-> lvl == scc_pkg::LVL_OFF && $past(deact))
    else $error("supply removed before card lines");
  after_down_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $fell(deact) |-> mode == scc_pkg::MODE_ACTIVE)
    else $error("powerdown did not return to active");
  hold_desel_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    cs_n && $past(cs_n) && $stable(lvl) && $past(lvl) == $past(lvl, 2)
    |-> $stable(to_card) && $stable(card_reset_out))
    else $error("card lines changed while deselected");
endmodule

// File: scc_pkg.sv
package scc_pkg;
  // card clock source codes, written as {reset, serial line}
  localparam logic [1:0] CLK_SYNC = 2'h0;
  localparam logic [1:0] CLK_DIV4 = 2'h1;
  localparam logic [1:0] CLK_DIV2 = 2'h3;
  localparam logic [1:0] CLK_DIV1 = 2'h2;

  typedef enum logic [2:0] {
    MODE_STANDBY,
    MODE_PROG,
    MODE_ACTIVE,
    MODE_TRANS,
    MODE_IDLE
  } scc_mode_e;

  typedef struct packed {
    logic vcc_high;
    logic [1:0] clk_sel;
  } scc_cfg_s;

  typedef struct packed {
    logic supply_uv;
    logic overcurrent;
    logic overtemp;
  } scc_fault_s;

  // state 4: synchronous clock, 5 V supply
  localparam scc_cfg_s CFG_RESET = '{vcc_high: 1'b1, clk_sel: CLK_SYNC};

  // sequencer levels: how many card line groups are enabled
  localparam logic [2:0] LVL_OFF = 3'h0;
  localparam logic [2:0] LVL_IO = 3'h1;
  localparam logic [2:0] LVL_CLK = 3'h2;
  localparam logic [2:0] LVL_AUX = 3'h3;
  localparam logic [2:0] LVL_RST = 3'h4;

  localparam int CLK_PERIOD_NS = 8;
  localparam int SEQ_STEP_NS = 1000;
  localparam int SEQ_STEP_CYCLES = (SEQ_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_TIME_MS = 160;
  localparam int OC_CYCLES = (OC_TIME_MS * 1000000) / CLK_PERIOD_NS;
endpackage

// File: scc_clk_sel.sv
`timescale 1ns/10ps
module scc_clk_sel (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic sync_clock_in,
  input wire logic async_clock_in,
  input wire logic [1:0] sel,
  input wire logic run,
  output logic card_clock_out
);
  logic async_q;
  logic [1:0] div;
  logic [1:0] cur_sel;
  logic gate;
  wire async_rise = async_clock_in & ~async_q;

  // candidate level of each source
  function automatic logic pick(input logic [1:0] s, input logic sy, input logic as,
                                input logic [1:0] d);
    logic v;
    v = sy;
    case (s)
      scc_pkg::CLK_DIV1: v = as;
      scc_pkg::CLK_DIV2: v = d[0];
      scc_pkg::CLK_DIV4: v = d[1];
      default: v = sy;
    endcase
    return v;
  endfunction

  wire cand_cur = pick(cur_sel, sync_clock_in, async_clock_in, div);
  wire cand_new = pick(sel, sync_clock_in, async_clock_in, div);
  // switch only while both old output and new source are low
  wire swap_ok = ~card_clock_out & ~cand_new;

  // divider counts async rising edges; gate opens and closes only on low phases
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      async_q <= 1'b0;
      div <= 2'h0;
      cur_sel <= scc_pkg::CLK_SYNC;
      gate <= 1'b0;
      card_clock_out <= 1'b0;
    end else begin
      async_q <= async_clock_in;
      div <= async_rise ? div + 2'h1 : div;
      cur_sel <= swap_ok ? sel : cur_sel;
      gate <= run ? (gate | ~cand_cur) : (gate & cand_cur);
      card_clock_out <= gate & cand_cur & (swap_ok ? cand_new : 1'b1);
    end
  end

  sel_on_low_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !$stable(cur_sel) |-> !$past(card_clock_out))
    else $error("clock source changed while card clock high");
  gate_low_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(gate) |-> !card_clock_out)
    else $error("clock gate opened during a high phase");
endmodule

// File: scc_card_model.sv
`timescale 1ns/10ps
// card side: converter output ramp and pulled-up card contact wires
module scc_card_model #(
  parameter int RAMP = 4
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic card_supply_on,
  input wire logic card_serial_line_oe_n,
  input wire logic card_aux_four_oe_n,
  input wire logic card_aux_eight_oe_n,
  input wire logic card_tx_low,
  output logic card_supply_ok,
  output logic card_serial_line_in,
  output logic card_aux_four_in,
  output logic card_aux_eight_in
);
  int ramp_cnt;
  // supply crosses the threshold a fixed time after the converter starts
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ramp_cnt <= 0;
      card_supply_ok <= 1'b0;
    end else if (!card_supply_on) begin
      ramp_cnt <= 0;
      card_supply_ok <= 1'b0;
    end else begin
      if (ramp_cnt < RAMP) ramp_cnt <= ramp_cnt + 1;
      card_supply_ok <= (ramp_cnt >= RAMP - 1);
    end
  end
  // a wire reads low whenever either party pulls it
  assign card_serial_line_in = card_serial_line_oe_n & ~card_tx_low;
  assign card_aux_four_in = card_aux_four_oe_n;
  assign card_aux_eight_in = card_aux_eight_oe_n;
endmodule

// File: scc_ctrl_bench.sv
`timescale 1ns/10ps
module scc_ctrl_bench;
  logic sys_clk, arst_n, cs_n, power_request, host_mode_low, host_reset, hio_drv;
  logic card_present, card_tx_low, sync_clock_in, async_clock_in, card_supply_ok;
  logic ms_out, ms_oe_n, hio_oe_n, ha4_oe_n, ha8_oe_n, card_supply_on, card_supply_high;
  logic card_clock_out, card_reset_out, cio_in, cio_oe_n, ca4_in, ca4_oe_n, ca8_in, ca8_oe_n;
  logic wake_n;
  scc_pkg::scc_fault_s faults;
  scc_pkg::scc_mode_e mode;
  int mismatches, cmp_count, seed, cnt;
  // wired levels: host may force the mode pin, all lines are pulled up
  wire logic ms_in = ~host_mode_low & (ms_oe_n | ms_out);
  wire logic hio_in = hio_drv & hio_oe_n;

  scc_ctrl #(.OC_CYCLES(20), .STEP_CYCLES(3)) u_scc_ctrl (.sys_clk(sys_clk), .arst_n(arst_n),
    .cs_n(cs_n), .power_request(power_request), .mode_status_pin_in(ms_in),
    .mode_status_pin_out(ms_out), .mode_status_pin_oe_n(ms_oe_n), .host_reset(host_reset),
    .host_io_in(hio_in), .host_io_out(), .host_io_oe_n(hio_oe_n),
    .host_aux_four_in(ha4_oe_n), .host_aux_four_out(), .host_aux_four_oe_n(ha4_oe_n),
    .host_aux_eight_in(ha8_oe_n), .host_aux_eight_out(), .host_aux_eight_oe_n(ha8_oe_n),
    .sync_clock_in(sync_clock_in), .async_clock_in(async_clock_in),
    .card_present(card_present), .card_supply_ok(card_supply_ok), .faults(faults),
    .card_supply_on(card_supply_on), .card_supply_high(card_supply_high),
    .card_clock_out(card_clock_out), .card_reset_out(card_reset_out),
    .card_serial_line_in(cio_in), .card_serial_line_out(), .card_serial_line_oe_n(cio_oe_n),
    .card_aux_four_in(ca4_in), .card_aux_four_out(), .card_aux_four_oe_n(ca4_oe_n),
    .card_aux_eight_in(ca8_in), .card_aux_eight_out(), .card_aux_eight_oe_n(ca8_oe_n),
    .wake_n(wake_n), .mode(mode));

  scc_card_model #(.RAMP(4)) u_scc_card_model (.sys_clk(sys_clk), .arst_n(arst_n),
    .card_supply_on(card_supply_on), .card_serial_line_oe_n(cio_oe_n),
    .card_aux_four_oe_n(ca4_oe_n), .card_aux_eight_oe_n(ca8_oe_n), .card_tx_low(card_tx_low),
    .card_supply_ok(card_supply_ok), .card_serial_line_in(cio_in),
    .card_aux_four_in(ca4_in), .card_aux_eight_in(ca8_in));

  // system clock and two slow clock sources
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    async_clock_in = 1'b0;
    forever begin
      repeat (2) @(negedge sys_clk);
      async_clock_in = ~async_clock_in;
    end
  end
  initial begin
    sync_clock_in = 1'b0;
    forever begin
      repeat (5) @(negedge sys_clk);
      sync_clock_in = ~sync_clock_in;
    end
  end

  task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // count rising card clock edges over n cycles
  task automatic clk_rises(input int n, output int c);
    logic p;
    c = 0;
    for (int i = 0; i < n; i++) begin
      p = card_clock_out;
      cyc(1);
      if (!p && card_clock_out) c++;
    end
  endtask

  // status meaning follows the power request level
  function automatic logic exp_status(input logic pr, input logic present, input logic ok);
    return pr ? ok : present;
  endfunction

  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // program one supply and clock state through the select edges
  task automatic prog(input logic [2:0] s);
    host_mode_low = 1'b1;
    cs_n = 1'b0;
    cyc(3);
    chk("prog_mode", mode, scc_pkg::MODE_PROG);
    chk("prog_oe_n", ms_oe_n, 1'b1);
    {power_request, host_reset, hio_drv} = s;
    cyc(2);
    cs_n = 1'b1;
    cyc(3);
    chk("vcc_high", card_supply_high, s[2]);
    chk("post_prog", mode, scc_pkg::MODE_STANDBY);
    host_mode_low = 1'b0;
    {power_request, host_reset, hio_drv} = 3'h1;
    cyc(2);
  endtask

  // track the order of card line groups: io, aux, reset
  task automatic seq(input logic up);
    int t[3];
    logic [2:0] v;
    t = '{-1, -1, -1};
    for (int i = 0; i < 100; i++) begin
      v = {card_reset_out, ca4_oe_n, cio_oe_n};
      for (int k = 0; k < 3; k++) if (t[k] < 0 && v[k] === up) t[k] = i;
      if (up ? mode === scc_pkg::MODE_TRANS : card_supply_on === 1'b0) break;
      cyc(1);
    end
    if (up) chk("up_order", {t[0] < t[1], t[1] < t[2]}, 4'h3);
    else chk("down_order", {t[2] < t[1], t[1] < t[0]}, 4'h3);
    if (!up) chk("lines_low", {cio_oe_n, ca4_oe_n, ca8_oe_n, card_clock_out}, 4'h0);
    chk("seq_done", up ? mode === scc_pkg::MODE_TRANS : card_supply_on, up);
  endtask

  task automatic pwr_up;
    power_request = 1'b0;
    cyc(2);
    power_request = 1'b1;
    cyc(2);
    chk("supply_on", card_supply_on, 1'b1);
    seq(1'b1);
  endtask

  initial begin
    arst_n = 1'b0;
    {cs_n, power_request, host_mode_low, host_reset, hio_drv} = 5'h11;
    {card_present, card_tx_low} = 2'h0;
    faults = '0;
    mismatches = 0;
    cmp_count = 0;
    seed = $urandom(32'h718a);
    cyc(2);
    arst_n = 1'b1;
    cyc(1);
    chk("rst_mode", mode, scc_pkg::MODE_STANDBY);
    chk("rst_vcc", card_supply_high, 1'b1);
    chk("rst_wake", {card_supply_on, wake_n, ms_oe_n}, 3'h3);
    $display("test reset done");
    for (int s = 0; s < 8; s++) prog(3'(s));
    repeat (3) prog(3'($urandom % 8));
    prog(3'h7);
    $display("test programming done");
    card_present = 1'b1;
    cyc(3);
    chk("wake_set", wake_n, 1'b0);
    cs_n = 1'b0;
    cyc(3);
    chk("poll_mode", mode, scc_pkg::MODE_ACTIVE);
    chk("poll_oe", ms_oe_n, 1'b0);
    cs_n = 1'b1;
    cyc(3);
    chk("wake_clr", wake_n, 1'b1);
    repeat (6) begin
      card_present = 1'($urandom % 2);
      cs_n = 1'b0;
      cyc(3);
      chk("poll_card", ms_out, exp_status(1'b0, card_present, 1'b1));
      cs_n = 1'b1;
      cyc(3);
      chk("standby", mode, scc_pkg::MODE_STANDBY);
    end
    card_present = 1'b1;
    $display("test status done");
    host_reset = 1'b1;
    cs_n = 1'b0;
    cyc(3);
    pwr_up();
    chk("trans_stat", ms_out, exp_status(1'b1, 1'b1, 1'b1));
    chk("aux_idle", {ca4_oe_n, ca8_oe_n, ha4_oe_n, ha8_oe_n}, 4'hf);
    clk_rises(80, cnt);
    chk("clk_div2", cnt >= 9 && cnt <= 11, 1'b1);
    hio_drv = 1'b0;
    cyc(2);
    chk("io_to_card", cio_oe_n, 1'b0);
    hio_drv = 1'b1;
    card_tx_low = 1'b1;
    cyc(2);
    chk("io_to_host", hio_oe_n, 1'b0);
    card_tx_low = 1'b0;
    cs_n = 1'b1;
    cyc(2);
    host_reset = 1'b0;
    cyc(3);
    chk("hold_rst", {card_reset_out, hio_oe_n}, 2'h3);
    chk("idle_pwr", card_supply_on, 1'b1);
    clk_rises(40, cnt);
    chk("idle_clk", cnt >= 4 && cnt <= 6, 1'b1);
    cs_n = 1'b0;
    cyc(3);
    chk("rst_follow", card_reset_out, 1'b0);
    host_reset = 1'b1;
    cyc(3);
    power_request = 1'b0;
    seq(1'b0);
    chk("pd_mode", mode, scc_pkg::MODE_ACTIVE);
    cs_n = 1'b1;
    cyc(3);
    chk("pd_stby", mode, scc_pkg::MODE_STANDBY);
    $display("test power sequence done");
    cs_n = 1'b0;
    cyc(3);
    pwr_up();
    faults.overtemp = 1'b1;
    seq(1'b0);
    cyc(2);
    chk("overload", ms_out, 1'b0);
    faults = '0;
    pwr_up();
    faults.overcurrent = 1'b1;
    cyc(10);
    faults.overcurrent = 1'b0;
    cyc(2);
    chk("oc_short", card_supply_on, 1'b1);
    faults.overcurrent = 1'b1;
    cyc(15);
    chk("oc_restart", mode, scc_pkg::MODE_TRANS);
    seq(1'b0);
    faults = '0;
    pwr_up();
    card_present = 1'b0;
    seq(1'b0);
    chk("pull_mode", mode, scc_pkg::MODE_ACTIVE);
    $display("test faults done");
    cs_n = 1'b1;
    cyc(3);
    prog(3'h4);
    {card_present, host_reset} = 2'h3;
    cs_n = 1'b0;
    cyc(3);
    pwr_up();
    clk_rises(80, cnt);
    chk("clk_sync", cnt >= 7 && cnt <= 9, 1'b1);
    cs_n = 1'b1;
    cyc(3);
    clk_rises(40, cnt);
    chk("idle_sync", cnt == 0, 1'b1);
    $display("test sync clock done");
    end_sim();
  end

  // cut a hang short well after the expected run length
  initial begin
    #200000;
    mismatches++;
    $display("watchdog expired");
    end_sim();
  end
endmodule
